// >>> hdl/cog_pkg.sv
package cog_pkg;

  // Reference clock derivation from the 40 MHz core clock
  localparam int unsigned CORE_CLK_HZ    = 40_000_000;
  localparam int unsigned FAST_OSC_HZ    = 8_000_000;
  localparam int unsigned INSTR_DIV      = 4;
  localparam int unsigned FAST_DIV       = CORE_CLK_HZ / FAST_OSC_HZ;
  localparam logic [2:0]  FAST_DIV_LAST  = 3'(FAST_DIV - 1);
  localparam logic [2:0]  INSTR_DIV_LAST = 3'(INSTR_DIV - 1);

  // clock_source_select codes
  localparam logic [1:0] CS_FAST_OSC = 2'h0;
  localparam logic [1:0] CS_INSTR    = 2'h1;
  localparam logic [1:0] CS_SYSTEM   = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_DEADBAND  = 8'h08;
  localparam logic [7:0] OFS_BLANK     = 8'h0C;
  localparam logic [7:0] OFS_PHASE     = 8'h10;
  localparam logic [7:0] OFS_OVERRIDE  = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // generator_control_0 fields
  localparam int unsigned C0_ENABLE   = 7;
  localparam int unsigned C0_PRI_OE   = 6;
  localparam int unsigned C0_SEC_OE   = 5;
  localparam int unsigned C0_PRI_POL  = 4;
  localparam int unsigned C0_SEC_POL  = 3;
  localparam int unsigned C0_CS_LSB   = 0;
  // generator_control_1 fields
  localparam int unsigned C1_RISE_MODE = 7;
  localparam int unsigned C1_FALL_MODE = 6;
  localparam int unsigned C1_RS_LSB    = 3;
  localparam int unsigned C1_FS_LSB    = 0;
  // Packed 4-bit count fields: high nibble rising, low nibble falling
  localparam int unsigned RISE_NIB_LSB = 4;
  localparam int unsigned FALL_NIB_LSB = 0;
  // Override levels
  localparam int unsigned OVR_PRI = 0;
  localparam int unsigned OVR_SEC = 1;

  // Reset values
  localparam logic [7:0] CONTROL_0_RST = 8'h00;
  localparam logic [7:0] CONTROL_1_RST = 8'h00;
  localparam logic [7:0] DEADBAND_RST  = 8'h00;
  localparam logic [7:0] BLANK_RST     = 8'h00;
  localparam logic [7:0] PHASE_RST     = 8'h00;
  localparam logic [7:0] OVERRIDE_RST  = 8'h00;

  // Interval timers
  localparam int unsigned NUM_TMR = 5;
  localparam int unsigned T_PH    = 0;
  localparam int unsigned T_RDB   = 1;
  localparam int unsigned T_FDB   = 2;
  localparam int unsigned T_RBLK  = 3;
  localparam int unsigned T_FBLK  = 4;

endpackage : cog_pkg

// >>> hdl/complementary_pwm_deadband.sv
`timescale 1ns/1ps
module complementary_pwm_deadband
  import cog_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [7:0]  event_src_i,
  output logic             primary_pin_o,
  output logic             primary_pin_oe_o,
  output logic             secondary_pin_o,
  output logic             secondary_pin_oe_o
);

  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [7:0]  db_q;
  logic [7:0]  blk_q;
  logic [7:0]  ph_q;
  logic [7:0]  ovr_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        rd_wait_q;
  logic [7:0]  rd_addr_q;
  logic [31:0] hrdata_q;
  logic        take;
  logic        mapped;

  logic        en;
  logic [1:0]  clk_sel;
  logic [2:0]  div_q;
  logic [2:0]  div_last;
  logic        ref_tick;
  logic [7:0]  src_s1_q;
  logic [7:0]  src_s2_q;
  logic        rise_in;
  logic        fall_in;
  logic        rise_prev_q;
  logic        fall_prev_q;
  logic        rise_raw;
  logic        fall_raw;
  logic        rise_ev;
  logic        fall_ev;
  logic        rise_out;
  logic        pri_set;
  logic        sec_set;
  logic        active_q;
  logic        pri_q;
  logic        sec_q;

  logic [NUM_TMR-1:0] tmr_start;
  logic [NUM_TMR-1:0] tmr_cancel;
  logic [NUM_TMR-1:0] tmr_run_q;
  logic [NUM_TMR-1:0] tmr_done;
  logic [3:0]         tmr_limit [NUM_TMR];
  logic [3:0]         tmr_cnt_q [NUM_TMR];

  // ---------------- AHB-Lite slave ----------------
  assign mapped      = (haddr_i[31:8] == 24'h00_0000);
  assign take        = hsel_i & htrans_i[1] & hready_i;
  assign hresp_o     = 1'b0;
  assign hreadyout_o = ~rd_wait_q;
  assign hrdata_o    = hrdata_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_wait_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite_i & mapped;
      rd_wait_q <= take & ~hwrite_i;
      if (take) begin
        wr_addr_q <= haddr_i[7:0];
        rd_addr_q <= mapped ? haddr_i[7:0] : 8'hFF;
      end
    end
  end

  // Read data is captured one cycle late so a preceding write is visible
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      unique case (rd_addr_q)
        OFS_CONTROL_0: hrdata_q <= {24'h00_0000, ctrl0_q};
        OFS_CONTROL_1: hrdata_q <= {24'h00_0000, ctrl1_q};
        OFS_DEADBAND:  hrdata_q <= {24'h00_0000, db_q};
        OFS_BLANK:     hrdata_q <= {24'h00_0000, blk_q};
        OFS_PHASE:     hrdata_q <= {24'h00_0000, ph_q};
        OFS_OVERRIDE:  hrdata_q <= {24'h00_0000, ovr_q};
        OFS_STATUS:    hrdata_q <= {26'h000_0000, active_q, tmr_run_q[T_FDB],
                                    tmr_run_q[T_RDB], 1'b0, sec_q, pri_q};
        default:       hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl0_q <= CONTROL_0_RST;
      ctrl1_q <= CONTROL_1_RST;
      db_q    <= DEADBAND_RST;
      blk_q   <= BLANK_RST;
      ph_q    <= PHASE_RST;
      ovr_q   <= OVERRIDE_RST;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        OFS_CONTROL_0: ctrl0_q <= hwdata_i[7:0];
        OFS_CONTROL_1: ctrl1_q <= hwdata_i[7:0];
        OFS_DEADBAND:  db_q    <= hwdata_i[7:0];
        OFS_BLANK:     blk_q   <= hwdata_i[7:0];
        OFS_PHASE:     ph_q    <= {4'h0, hwdata_i[3:0]};
        OFS_OVERRIDE:  ovr_q   <= {6'h00, hwdata_i[1:0]};
        default:       ;
      endcase
    end
  end

  // ---------------- Reference clock enable ----------------
  assign en      = ctrl0_q[C0_ENABLE];
  assign clk_sel = ctrl0_q[C0_CS_LSB +: 2];
  assign div_last = (clk_sel == CS_FAST_OSC) ? FAST_DIV_LAST : INSTR_DIV_LAST;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 3'h0;
    end else if (div_q >= div_last) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_comb begin
    unique case (clk_sel)
      CS_FAST_OSC: ref_tick = (div_q == div_last);
      CS_INSTR:    ref_tick = (div_q == div_last);
      default:     ref_tick = 1'b1;
    endcase
  end

  // ---------------- Event inputs ----------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_s1_q <= 8'h00;
      src_s2_q <= 8'h00;
    end else begin
      src_s1_q <= event_src_i;
      src_s2_q <= src_s1_q;
    end
  end

  assign rise_in = src_s2_q[ctrl1_q[C1_RS_LSB +: 3]];
  assign fall_in = src_s2_q[ctrl1_q[C1_FS_LSB +: 3]];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_prev_q <= 1'b0;
      fall_prev_q <= 1'b0;
    end else if (ref_tick) begin
      rise_prev_q <= rise_in;
      fall_prev_q <= fall_in;
    end
  end

  // Mode bit set means level sensing; level events are gated by the phase flag
  assign rise_raw = ctrl1_q[C1_RISE_MODE] ? (rise_in & ~active_q)
                                          : (rise_in & ~rise_prev_q);
  assign fall_raw = ctrl1_q[C1_FALL_MODE] ? (~fall_in & active_q)
                                          : (~fall_in & fall_prev_q);

  // Falling event wins a same-tick tie; blanking masks the opposite input
  assign fall_ev = ref_tick & en & fall_raw & ~tmr_run_q[T_RBLK];
  assign rise_ev = ref_tick & en & rise_raw & ~tmr_run_q[T_FBLK] & ~fall_ev;

  // ---------------- Interval timers ----------------
  assign tmr_limit[T_PH]   = ph_q[3:0];
  assign tmr_limit[T_RDB]  = db_q[RISE_NIB_LSB +: 4];
  assign tmr_limit[T_FDB]  = db_q[FALL_NIB_LSB +: 4];
  assign tmr_limit[T_RBLK] = blk_q[RISE_NIB_LSB +: 4];
  assign tmr_limit[T_FBLK] = blk_q[FALL_NIB_LSB +: 4];

  assign tmr_start[T_PH]   = rise_ev;
  assign tmr_start[T_RDB]  = rise_out;
  assign tmr_start[T_FDB]  = fall_ev;
  assign tmr_start[T_RBLK] = rise_ev;
  assign tmr_start[T_FBLK] = fall_ev;
  assign tmr_cancel[T_PH]   = fall_ev;
  assign tmr_cancel[T_RDB]  = fall_ev;
  assign tmr_cancel[T_FDB]  = rise_out;
  assign tmr_cancel[T_RBLK] = 1'b0;
  assign tmr_cancel[T_FBLK] = 1'b0;

  // A timer started on a tick expires after exactly limit further ticks
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    assign tmr_done[i] = tmr_run_q[i] & ref_tick & ~tmr_start[i] & ~tmr_cancel[i]
                       & (tmr_cnt_q[i] + 4'h1 == tmr_limit[i]);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tmr_run_q[i] <= 1'b0;
        tmr_cnt_q[i] <= 4'h0;
      end else if (!en) begin
        tmr_run_q[i] <= 1'b0;
        tmr_cnt_q[i] <= 4'h0;
      end else if (tmr_start[i]) begin
        tmr_run_q[i] <= (tmr_limit[i] != 4'h0);
        tmr_cnt_q[i] <= 4'h0;
      end else if (tmr_cancel[i]) begin
        tmr_run_q[i] <= 1'b0;
      end else if (tmr_done[i]) begin
        tmr_run_q[i] <= 1'b0;
      end else if (tmr_run_q[i] && ref_tick) begin
        tmr_cnt_q[i] <= tmr_cnt_q[i] + 4'h1;
      end
    end
  end

  // ---------------- Drive sequencing ----------------
  assign rise_out = (rise_ev & (ph_q[3:0] == 4'h0)) | tmr_done[T_PH];
  assign pri_set  = (rise_out & (tmr_limit[T_RDB] == 4'h0)) | tmr_done[T_RDB];
  assign sec_set  = (fall_ev & (tmr_limit[T_FDB] == 4'h0)) | tmr_done[T_FDB];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_q <= 1'b0;
    end else if (!en || fall_ev) begin
      active_q <= 1'b0;
    end else if (rise_ev) begin
      active_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pri_q <= 1'b0;
    end else if (!en) begin
      pri_q <= 1'b0;
    end else if (fall_ev) begin
      pri_q <= 1'b0;
    end else if (pri_set) begin
      pri_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_q <= 1'b1;
    end else if (!en) begin
      sec_q <= 1'b1;
    end else if (rise_out) begin
      sec_q <= 1'b0;
    end else if (sec_set) begin
      sec_q <= 1'b1;
    end
  end

  // ---------------- Pins ----------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      primary_pin_o      <= 1'b0;
      secondary_pin_o    <= 1'b0;
      primary_pin_oe_o   <= 1'b0;
      secondary_pin_oe_o <= 1'b0;
    end else begin
      primary_pin_oe_o   <= ctrl0_q[C0_PRI_OE];
      secondary_pin_oe_o <= ctrl0_q[C0_SEC_OE];
      primary_pin_o      <= en ? (pri_q ^ ctrl0_q[C0_PRI_POL])
                               : ovr_q[OVR_PRI];
      secondary_pin_o    <= en ? (sec_q ^ ctrl0_q[C0_SEC_POL])
                               : ovr_q[OVR_SEC];
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence read_wait_s;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  read_timing_a: assert property ((take && !hwrite_i) |=> read_wait_s)
    else $error("read not answered after one wait state");

  disabled_override_a: assert property (!en |=> primary_pin_o == $past(ovr_q[OVR_PRI])
                                        && secondary_pin_o == $past(ovr_q[OVR_SEC]))
    else $error("override levels not shown while disabled");

  polarity_apply_a: assert property (en |=> primary_pin_o ==
                                     ($past(pri_q) ^ $past(ctrl0_q[C0_PRI_POL])))
    else $error("primary pin polarity wrong");

  enable_state_a: assert property ((!en ##1 en) |-> !pri_q && sec_q)
    else $error("wrong drive state right after enable");

  fall_clears_a: assert property (fall_ev |=> !pri_q && !active_q)
    else $error("falling event did not clear primary");

  zero_delay_a: assert property ((rise_ev && ph_q[3:0] == 4'h0
                                  && db_q[RISE_NIB_LSB +: 4] == 4'h0) |=> pri_q && !sec_q)
    else $error("primary not immediate with zero delays");

  primary_cause_a: assert property ($rose(pri_q) |-> $past(pri_set))
    else $error("primary rose without dead band expiry");

  rise_overlap_a: assert property ((fall_ev && tmr_run_q[T_RDB])
                                   |=> !pri_q && !tmr_run_q[T_RDB])
    else $error("rising dead band not suppressed by fall");

  fall_overlap_a: assert property ((rise_out && tmr_run_q[T_FDB])
                                   |=> !sec_q && !tmr_run_q[T_FDB])
    else $error("falling dead band not suppressed by rise");

  rise_blank_a: assert property ((fall_ev && blk_q[FALL_NIB_LSB +: 4] != 4'h0)
                                 |=> tmr_run_q[T_FBLK] && !rise_ev)
    else $error("rising input not blanked after fall");

  fall_blank_a: assert property ((rise_ev && blk_q[RISE_NIB_LSB +: 4] != 4'h0)
                                 |=> tmr_run_q[T_RBLK] && !fall_ev)
    else $error("falling input not blanked after rise");

  // Phase timer must start and secondary must not fall in the cycle after the rising event
  phase_start_a: assert property ((rise_ev && ph_q[3:0] != 4'h0)
                                  |=> tmr_run_q[T_PH] && !$fell(sec_q))
    else $error("phase delay not started or secondary cleared early");

  counter_bound_a: assert property (tmr_run_q[T_RDB] |->
                                    tmr_cnt_q[T_RDB] < tmr_limit[T_RDB])
    else $error("dead band counter past its limit");

  fall_bound_a: assert property (tmr_run_q[T_FDB] |->
                                 tmr_cnt_q[T_FDB] < tmr_limit[T_FDB])
    else $error("falling dead band counter past its limit");

  system_tick_a: assert property ((clk_sel == CS_SYSTEM) |-> ref_tick)
    else $error("system clock selection lost ticks");

endmodule : complementary_pwm_deadband

// >>> testbench/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
  input  wire logic       clk_i,
  input  wire logic       pri_pin_i,
  input  wire logic       pri_oe_i,
  input  wire logic       sec_pin_i,
  input  wire logic       sec_oe_i,
  output logic      [7:0] event_src_o,
  output logic            gate_pri_o,
  output logic            gate_sec_o
);
  logic [7:0] src_q = 8'h00;

  // Gate driver inputs have pull-downs, so a released pin reads low
  assign gate_pri_o  = pri_oe_i ? pri_pin_i : 1'b0;
  assign gate_sec_o  = sec_oe_i ? sec_pin_i : 1'b0;
  assign event_src_o = src_q;

  // Sources move just after a core edge and stay put until told otherwise
  task automatic drive(input int idx, input logic v);
    @(posedge clk_i);
    src_q[idx] <= v;
  endtask : drive
endmodule : far_side_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cog_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        arst_n_i   = 1'b0;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0000_0000;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  src;
  logic        pri;
  logic        pri_oe;
  logic        sec;
  logic        sec_oe;
  logic        gp;
  logic        gs;
  logic        pri_hi     = 1'b0;
  logic        sec_hi     = 1'b0;
  int          miscompares = 0;
  int          checked     = 0;
  int          cyc         = 0;
  int          n0;
  int          n;
  int          g;
  int          d;

  complementary_pwm_deadband u_dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .event_src_i(src), .primary_pin_o(pri), .primary_pin_oe_o(pri_oe),
    .secondary_pin_o(sec), .secondary_pin_oe_o(sec_oe));

  far_side_model u_far (
    .clk_i(core_clk_i), .pri_pin_i(pri), .pri_oe_i(pri_oe), .sec_pin_i(sec),
    .sec_oe_i(sec_oe), .event_src_o(src), .gate_pri_o(gp), .gate_sec_o(gs));

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (gp === 1'b1) pri_hi <= 1'b1;
    if (gs === 1'b1) sec_hi <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic r;
    @(posedge core_clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(negedge core_clk_i);
      r = hready;
      @(posedge core_clk_i);
    end while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge core_clk_i);
      r  = hready;
      rd = hrdata;
      @(posedge core_clk_i);
    end while (r !== 1'b1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] x;
    bus(1'b1, a, {24'h00_0000, v}, x);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, exp, "register read");
  endtask : rdchk

  // Count cycles until a gate reaches a level; -1 when it does not within 400 cycles
  task automatic wait_gate(input logic which, input logic v, output int k);
    k = 0;
    while (k < 400) begin
      k++;
      @(negedge core_clk_i);
      if ((which ? gs : gp) === v) return;
    end
    k = -1;
  endtask : wait_gate

  // Disable first so each setup starts from the documented enable state
  task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] db,
                     input logic [7:0] blk, input logic [7:0] ph);
    wr(OFS_CONTROL_0, 8'h00);
    wr(OFS_CONTROL_1, c1);
    wr(OFS_DEADBAND, db);
    wr(OFS_BLANK, blk);
    wr(OFS_PHASE, ph);
    wr(OFS_CONTROL_0, c0);
  endtask : cfg

  task automatic blank_run(input logic [7:0] blk, input logic exp);
    cfg(8'he2, 8'h01, 8'h00, blk, 8'h00);
    u_far.drive(1, 1'b1);
    u_far.drive(0, 1'b1);
    wait_gate(1'b0, 1'b1, n);
    u_far.drive(0, 1'b0);
    u_far.drive(1, 1'b0);
    wait_gate(1'b0, 1'b0, n);
    pri_hi = 1'b0;
    u_far.drive(0, 1'b1);
    repeat (12) @(negedge core_clk_i);
    check(32'(pri_hi), 32'(exp), "rising input after fall");
    u_far.drive(0, 1'b0);
  endtask : blank_run

  initial begin
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    wr(OFS_CONTROL_1, 8'hff);
    rdchk(OFS_CONTROL_1, 32'h0000_00ff);
    wr(8'h80, 8'h5a);
    rdchk(8'h80, 32'h0000_0000);
    check(32'(hresp), 32'h0, "bus response");
    wr(OFS_OVERRIDE, 8'h01);
    wr(OFS_CONTROL_0, 8'h78);
    repeat (3) @(negedge core_clk_i);
    check(32'({gp, gs}), 32'h2, "override levels while disabled");
    wr(OFS_CONTROL_0, 8'h18);
    repeat (3) @(negedge core_clk_i);
    check(32'({pri_oe, sec_oe, gp, gs}), 32'h0, "pins released");
    cfg(8'he2, 8'h00, 8'h00, 8'h00, 8'h00);
    repeat (3) @(negedge core_clk_i);
    check(32'({gp, gs}), 32'h1, "state after enable");
    rdchk(OFS_STATUS, 32'h0000_0002);
    cfg(8'hfa, 8'h00, 8'h00, 8'h00, 8'h00);
    repeat (3) @(negedge core_clk_i);
    check(32'({gp, gs}), 32'h2, "inverted outputs");
    cfg(8'he2, 8'h00, 8'h00, 8'h00, 8'h00);
    u_far.drive(0, 1'b1);
    wait_gate(1'b1, 1'b0, n0);
    check(32'(gp), 32'h1, "primary with zero delays");
    check(32'(n0 >= 2 && n0 <= 6), 32'h1, "rising event latency");
    u_far.drive(0, 1'b0);
    wait_gate(1'b1, 1'b1, n);
    check(32'({gp, n >= 0}), 32'h1, "falling event outputs");
    for (int cs = 0; cs < 3; cs++) begin
      d = (cs == 0) ? int'(FAST_DIV) : ((cs == 1) ? int'(INSTR_DIV) : 1);
      cfg(8'he0 | 8'(cs), 8'h00, 8'h32, 8'h00, 8'h00);
      u_far.drive(0, 1'b1);
      wait_gate(1'b1, 1'b0, n);
      wait_gate(1'b0, 1'b1, g);
      check(32'(g >= 3 * d && g <= 4 * d), 32'h1, "rising dead band");
      u_far.drive(0, 1'b0);
      wait_gate(1'b0, 1'b0, n);
      wait_gate(1'b1, 1'b1, g);
      check(32'(g >= 2 * d && g <= 3 * d), 32'h1, "falling dead band");
    end
    cfg(8'he2, 8'h00, 8'h00, 8'h00, 8'h04);
    u_far.drive(0, 1'b1);
    wait_gate(1'b1, 1'b0, n);
    check(32'(n - n0 >= 4 && n - n0 <= 5), 32'h1, "phase delay");
    check(32'(gp), 32'h1, "dead band after phase delay");
    u_far.drive(0, 1'b0);
    cfg(8'he2, 8'h01, 8'h82, 8'h00, 8'h00);
    u_far.drive(1, 1'b1);
    u_far.drive(0, 1'b1);
    wait_gate(1'b1, 1'b0, n);
    pri_hi = 1'b0;
    u_far.drive(1, 1'b0);
    wait_gate(1'b1, 1'b1, g);
    check(32'({pri_hi, g >= 0}), 32'h1, "fall during rising dead band");
    u_far.drive(0, 1'b0);
    cfg(8'he2, 8'h01, 8'h28, 8'h00, 8'h00);
    u_far.drive(1, 1'b1);
    u_far.drive(0, 1'b1);
    wait_gate(1'b0, 1'b1, n);
    u_far.drive(1, 1'b0);
    wait_gate(1'b0, 1'b0, n);
    sec_hi = 1'b0;
    u_far.drive(0, 1'b0);
    u_far.drive(0, 1'b1);
    wait_gate(1'b0, 1'b1, g);
    check(32'({sec_hi, g >= 0}), 32'h1, "rise during falling dead band");
    u_far.drive(0, 1'b0);
    blank_run(8'h08, 1'b0);
    blank_run(8'h00, 1'b1);
    // Falling input edge-sensed, then level-sensed, with its source held low
    for (int m = 0; m < 2; m++) begin
      cfg(8'he2, m ? 8'h45 : 8'h05, 8'h00, 8'h00, 8'h00);
      u_far.drive(0, 1'b1);
      repeat (20) @(negedge core_clk_i);
      check(32'(gp), 32'(m == 0), "low fall source at rising event");
      u_far.drive(0, 1'b0);
    end
    // A rise source held high in level mode restarts the drive after a fall
    cfg(8'he2, 8'h81, 8'h00, 8'h00, 8'h00);
    u_far.drive(0, 1'b1);
    u_far.drive(1, 1'b1);
    u_far.drive(1, 1'b0);
    repeat (20) @(negedge core_clk_i);
    check(32'(gp), 32'h1, "level rise source held high");
    u_far.drive(0, 1'b0);
    end_of_test();
  end
endmodule : testbench
